// *** sfp_program_port.sv ***
// serial in-system programming port with flash array and AXI4-Lite status
`timescale 1ns/100ps
`include "sfp_regs.svh"

module sfp_program_port
  import sfp_pkg::*;
#(
  parameter int unsigned ADDR_W       = 13,
  parameter int unsigned BUSY_W       = 26,
  parameter int unsigned ERASE_CYCLES = `SFP_ERASE_CYCLES,
  parameter int unsigned SWC_CYCLES   = `SFP_SWC_CYCLES,
  parameter logic [7:0]  SIG_BYTE0    = 8'h11,  // arbitrary value
  parameter logic [7:0]  SIG_BYTE1    = 8'h22,  // arbitrary value
  parameter logic [7:0]  SIG_BYTE2    = 8'h33   // arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        holdReset,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // ---------------- link domain (sck) ----------------
  logic [2:0]  bitCnt;
  logic [6:0]  rxShift;
  logic [7:0]  rxByte;
  logic        rxToggle;
  logic [7:0]  txShift;
  logic [7:0]  txByte;

  // msb first shift in on rising edge
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt   <= 3'h0;
      rxShift  <= 7'h00;
      rxByte   <= 8'h00;
      rxToggle <= 1'b0;
    end else begin
      rxShift <= {rxShift[5:0], mosi};
      bitCnt  <= bitCnt + 3'h1;
      if (bitCnt == 3'h7) begin
        rxByte   <= {rxShift, mosi};
        rxToggle <= ~rxToggle;
      end
    end
  end

  // answer byte loaded at the byte boundary, then shifted out msb first;
  // txByte is settled by then because sck runs at most mclk/16
  always_ff @(negedge sck or negedge rst_b) begin
    if (!rst_b) begin
      txShift <= 8'h00;
      miso    <= 1'b0;
    end else if (bitCnt == 3'h0) begin
      txShift <= txByte;
      miso    <= txByte[7];
    end else begin
      txShift <= {txShift[6:0], 1'b0};
      miso    <= txShift[6];
    end
  end

  // ---------------- system domain (mclk) ----------------
  logic                holdSync1;
  logic                holdSync2;
  logic                tglSync1;
  logic                tglSync2;
  logic                tglSync3;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      holdSync1 <= 1'b0;
      holdSync2 <= 1'b0;
      tglSync1  <= 1'b0;
      tglSync2  <= 1'b0;
      tglSync3  <= 1'b0;
    end else begin
      holdSync1 <= holdReset;
      holdSync2 <= holdSync1;
      tglSync1  <= rxToggle;
      tglSync2  <= tglSync1;
      tglSync3  <= tglSync2;
    end
  end

  sfp_state_type       state;
  sfp_state_type       next_state;
  logic [7:0]          cmdByte;
  logic [7:0]          arg1;
  logic [7:0]          arg2;
  logic [7:0]          pageIdx;
  logic                progEnabled;
  logic [2:0]          lockBits;
  logic                serialEnable;
  logic [BUSY_W-1:0]   busyCnt;
  logic                erasing;
  logic [ADDR_W-1:0]   eraseAddr;
  logic [15:0]         byteCount;
  logic [7:0]          mem [2**ADDR_W];
  logic [7:0]          next_tx;

  wire rxEvent  = tglSync2 ^ tglSync3;
  wire busy     = (busyCnt != '0);
  // reset pin is a level: held high, bytes are decoded without any pulse
  wire byteGo   = rxEvent & holdSync2 & serialEnable & ~busy;
  wire inCmd    = (state == stCmd);
  wire inArg1   = (state == stArg1);
  wire inArg2   = (state == stArg2);
  wire inArg3   = (state == stArg3);
  wire inPage   = (state == stPage);
  wire isIsp    = (cmdByte == `SFP_OP_ISP);
  wire isRdPage = progEnabled & (cmdByte == `SFP_OP_READ_PAGE);
  wire isWrPage = progEnabled & (cmdByte == `SFP_OP_WRITE_PAGE);
  wire pageLast = (pageIdx == `SFP_PAGE_LAST);
  wire [ADDR_W-9:0] pageBase = arg1[ADDR_W-9:0];

  wire enableGo  = byteGo & inArg3 & isIsp & (arg1 == `SFP_ARG_ENABLE);
  wire eraseGo   = byteGo & inArg3 & progEnabled & isIsp
                   & (arg1[7:5] == `SFP_ARG_ERASE);
  wire lockGo    = byteGo & inArg3 & progEnabled & isIsp
                   & (arg1[7:2] == `SFP_ARG_LOCK);
  wire byteWrite = byteGo & inArg3 & progEnabled & ~lockBits[0]
                   & (cmdByte == `SFP_OP_WRITE_BYTE);
  wire pageWrite = byteGo & inPage & isWrPage & ~lockBits[0];
  wire pageDone  = byteGo & inPage & pageLast;
  wire writeTime = byteWrite | (pageDone & isWrPage);

  // lock select: {lock_select_hi, lock_select_lo}
  wire [1:0] lockSelect = arg1[1:0];
  wire [2:0] lockSet;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_lock
      assign lockSet[gi] = (lockSelect == 2'(gi + 1));
    end
  endgenerate

  // one port into the array: erase walk, byte write or page write
  wire               memWe   = erasing | byteWrite | pageWrite;
  wire [ADDR_W-1:0]  memWa   = erasing ? eraseAddr :
                               inPage  ? {pageBase, pageIdx} :
                                         {pageBase, arg2};
  wire [7:0]         memWd   = erasing ? `SFP_ERASED : rxByte;
  wire [7:0]         pageNext = pageIdx + 8'h01;
  wire [ADDR_W-1:0]  memRa   = inArg1 ? {rxByte[ADDR_W-9:0], 8'h00} :
                               inArg2 ? {pageBase, rxByte} :
                                        {pageBase, pageNext};
  wire [7:0]         memRd   = mem[memRa];
  wire [7:0]         sigByte = (rxByte[1:0] == 2'h0) ? SIG_BYTE0 :
                               (rxByte[1:0] == 2'h1) ? SIG_BYTE1 :
                               (rxByte[1:0] == 2'h2) ? SIG_BYTE2 : 8'h00;
  wire [7:0]         lockByte = 8'({lockBits, 2'b00});

  always_ff @(posedge mclk) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  always_comb begin
    next_state = state;
    if (byteGo) begin
      unique case (state)
        stCmd:  next_state = stArg1;
        stArg1: next_state = (isRdPage | isWrPage) ? stPage : stArg2;
        stArg2: next_state = stArg3;
        stArg3: next_state = stCmd;
        stPage: next_state = pageLast ? stCmd : stPage;
      endcase
    end
  end

  // byte to shift out during the next serial byte
  always_comb begin
    next_tx = 8'h00;
    if (inArg1 & isRdPage) begin
      next_tx = memRd;
    end else if (inArg2 & progEnabled) begin
      if (cmdByte == `SFP_OP_READ_BYTE) begin
        next_tx = memRd;
      end else if (cmdByte == `SFP_OP_READ_LOCK) begin
        next_tx = lockByte;
      end else if (cmdByte == `SFP_OP_READ_SIG) begin
        next_tx = sigByte;
      end
    end else if (inPage & isRdPage & ~pageLast) begin
      next_tx = memRd;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= stCmd;
      cmdByte <= 8'h00;
      arg1    <= 8'h00;
      arg2    <= 8'h00;
      txByte  <= 8'h00;
    end else if (!holdSync2) begin
      state   <= stCmd;
      txByte  <= 8'h00;
    end else if (byteGo) begin
      state   <= next_state;
      txByte  <= next_tx;
      if (inCmd) begin
        cmdByte <= rxByte;
      end
      if (inArg1) begin
        arg1 <= rxByte;
      end
      if (inArg2) begin
        arg2 <= rxByte;
      end
    end
  end

  // page position restarts at byte 0 and climbs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pageIdx <= 8'h00;
    end else if (byteGo) begin
      pageIdx <= inPage ? pageNext : 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      progEnabled <= 1'b0;
      lockBits    <= 3'h0;
    end else begin
      if (!holdSync2) begin
        progEnabled <= 1'b0;
      end else if (enableGo) begin
        progEnabled <= 1'b1;
      end
      if (eraseGo) begin
        lockBits <= 3'h0;
      end else if (lockGo) begin
        lockBits <= lockBits | lockSet;
      end
    end
  end

  // busy timers; bytes arriving meanwhile are dropped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busyCnt   <= '0;
      erasing   <= 1'b0;
      eraseAddr <= '0;
    end else begin
      if (eraseGo) begin
        busyCnt <= BUSY_W'(ERASE_CYCLES);
      end else if (writeTime) begin
        busyCnt <= BUSY_W'(SWC_CYCLES);
      end else if (busy) begin
        busyCnt <= busyCnt - BUSY_W'(1);
      end
      if (eraseGo) begin
        erasing   <= 1'b1;
        eraseAddr <= '0;
      end else if (erasing) begin
        eraseAddr <= eraseAddr + ADDR_W'(1);
        if (eraseAddr == '1) begin
          erasing <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      byteCount <= 16'h0000;
    end else if (byteGo) begin
      byteCount <= byteCount + 16'h0001;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  logic        awHave;
  logic        wHave;
  logic [7:0]  awAddrR;
  logic [31:0] wDataR;
  logic [3:0]  wStrbR;

  wire awFire   = awvalid & awready;
  wire wFire    = wvalid & wready;
  wire arFire   = arvalid & arready;
  wire writeGo  = awHave & wHave & ~bvalid;
  wire [7:0] wAddr = {awAddrR[7:2], 2'b00};
  wire [7:0] rAddr = {araddr[7:2], 2'b00};
  wire wCtrlHit = (wAddr == `SFP_CTRL_OFF);
  wire wKnown   = wCtrlHit | (wAddr == `SFP_STAT_OFF) | (wAddr == `SFP_COUNT_OFF);
  wire rCtrlHit = (rAddr == `SFP_CTRL_OFF);
  wire rStatHit = (rAddr == `SFP_STAT_OFF);
  wire rCntHit  = (rAddr == `SFP_COUNT_OFF);
  wire [31:0] statWord = 32'({cmdByte, 2'b00, lockBits, erasing, busy, progEnabled});
  wire [31:0] rWord = rCtrlHit ? {31'h0, serialEnable} :
                      rStatHit ? statWord :
                      rCntHit  ? {16'h0000, byteCount} : 32'h0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awHave  <= 1'b0;
      wHave   <= 1'b0;
      awAddrR <= 8'h00;
      wDataR  <= 32'h0;
      wStrbR  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      if (awFire) begin
        awHave  <= 1'b1;
        awAddrR <= awaddr;
      end else if (writeGo) begin
        awHave <= 1'b0;
      end
      if (wFire) begin
        wHave  <= 1'b1;
        wDataR <= wdata;
        wStrbR <= wstrb;
      end else if (writeGo) begin
        wHave <= 1'b0;
      end
      awready <= writeGo | ~(awHave | awFire);
      wready  <= writeGo | ~(wHave | wFire);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid       <= 1'b0;
      bresp        <= `SFP_RESP_OKAY;
      serialEnable <= `SFP_CTRL_RESET;
    end else if (writeGo) begin
      bvalid <= 1'b1;
      bresp  <= wKnown ? `SFP_RESP_OKAY : `SFP_RESP_SLVERR;
      if (wCtrlHit & wStrbR[0]) begin
        serialEnable <= wDataR[0];
      end
    end else if (bvalid & bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `SFP_RESP_OKAY;
    end else if (arFire) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rWord;
      rresp   <= (rCtrlHit | rStatHit | rCntHit) ? `SFP_RESP_OKAY : `SFP_RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

endmodule

// *** sfp_regs.svh ***
// constants of the serial flash program port: offsets, opcodes, fields, timing
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

`define SFP_CTRL_OFF       8'h00
`define SFP_STAT_OFF       8'h04
`define SFP_COUNT_OFF      8'h08
`define SFP_CTRL_RESET     1'b1

`define SFP_OP_ISP         8'hac
`define SFP_OP_READ_BYTE   8'h20
`define SFP_OP_WRITE_BYTE  8'h40
`define SFP_OP_READ_LOCK   8'h24
`define SFP_OP_READ_SIG    8'h28
`define SFP_OP_READ_PAGE   8'h30
`define SFP_OP_WRITE_PAGE  8'h50
`define SFP_ARG_ENABLE     8'h53
`define SFP_ARG_ERASE      3'h4
`define SFP_ARG_LOCK       6'h38
`define SFP_LOCK_POS       2
`define SFP_PAGE_LAST      8'hff
`define SFP_ERASED         8'hff

`define SFP_STAT_ENABLED   0
`define SFP_STAT_BUSY      1
`define SFP_STAT_ERASING   2
`define SFP_STAT_LOCK      3
`define SFP_STAT_CMD       8

`define SFP_MCLK_KHZ       125000
`define SFP_TERASE_MS      500
`define SFP_TSWC_OSC       64
`define SFP_TSWC_US        400
`define SFP_ERASE_CYCLES   (`SFP_TERASE_MS * `SFP_MCLK_KHZ)
`define SFP_SWC_CYCLES     (`SFP_TSWC_OSC + (`SFP_TSWC_US * `SFP_MCLK_KHZ) / 1000)

`define SFP_RESP_OKAY      2'h0
`define SFP_RESP_SLVERR    2'h2

`endif

// *** sfp_pkg.sv ***
// types of the serial flash program port
package sfp_pkg;
  typedef enum logic [2:0] {
    stCmd,
    stArg1,
    stArg2,
    stArg3,
    stPage
  } sfp_state_type;
endpackage

// *** sfp_program_port_checker.sv ***
// checker of bus handshakes and serial output timing
`timescale 1ns/100ps
module sfp_program_port_checker (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        sck,
  input wire logic        miso,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_answer;
    s_rd_take |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_unmapped;
    s_rd_take ##0 (araddr >= 8'h0c) |=> rresp == 2'h2 && rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_mapped;
    s_rd_take ##0 (araddr <= 8'h08 && araddr[1:0] == 2'h0) |=> rresp == 2'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read refused");
  property p_ar_refused;
    rvalid |-> !arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("read taken while busy");
  property p_aw_refused;
    s_wr_take |=> !awready && !wready;
  endproperty
  a_aw_refused: assert property (p_aw_refused) else $error("write taken twice");
  property p_b_answer;
    s_wr_take |=> ##[0:2] bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_miso;
    $changed(miso) |-> !sck;
  endproperty
  a_miso: assert property (p_miso) else $error("serial out moved with clock high");
endmodule
bind sfp_program_port sfp_program_port_checker chk_u (.mclk, .rst_b, .sck, .miso, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
  .rresp, .rvalid, .rready);

// *** sfp_programmer.sv ***
// serial programmer model acting as link master
`timescale 1ns/100ps
module sfp_programmer #(
  parameter int HALF = 65
) (
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF);
      sck = 1'b1;
      rx[i] = miso;
      #(HALF);
      sck = 1'b0;
    end
    mosi = ~tx[0];
  endtask
endmodule

// *** tb_serial_flash_program_port.sv ***
// self-checking bench of the serial flash program port
`timescale 1ns/100ps
module tb_serial_flash_program_port;
  logic        mclk = 0, rst_b = 0, holdReset = 1, sck, mosi, miso;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 0, araddr = 0, rx, v;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, r;
  logic [12:0] a;
  logic [4:0]  p;
  logic [2:0]  lk = 0;
  logic [7:0]  mem [8192];
  int          num_errors = 0, cmp_count = 0, sent = 0, seed = 32'h397b;
  always #4 mclk = ~mclk;
  sfp_program_port #(.ERASE_CYCLES(9000), .SWC_CYCLES(100)) dut_u (.mclk, .rst_b, .holdReset,
    .sck, .mosi, .miso, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  sfp_programmer prog_u (.sck, .mosi, .miso);
  task automatic final_report;
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout;
    num_errors++;
    final_report();
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) timeout();
    chk(bresp, er);
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) timeout();
    dt = rdata;
    rs = rresp;
    @(posedge mclk);
  endtask
  // poll until the port is no longer busy
  task automatic idle;
    int n;
    n = 0;
    @(posedge mclk);
    do begin
      rd(8'h04, d, r);
      n++;
    end while (d[1] !== 1'b0 && n < 5000);
    if (n >= 5000) timeout();
  endtask
  task automatic ins(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input logic [7:0] b3);
    prog_u.xfer(b0, rx);
    prog_u.xfer(b1, rx);
    prog_u.xfer(b2, rx);
    prog_u.xfer(b3, rx);
    sent += 4;
    idle();
  endtask
  task automatic byte_rw;
    a = 13'($random(seed));
    v = 8'($random(seed));
    ins(8'h40, {3'b000, a[12:8]}, a[7:0], v);
    if (!lk[0]) mem[a] = v;
    ins(8'h20, {3'b000, a[12:8]}, a[7:0], 8'h00);
    chk(rx, mem[a]);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (80) @(posedge mclk);
    rd(8'h00, d, r);
    chk(d, 32'h1);
    ins(8'hac, 8'h53, 8'h00, 8'h00);
    rd(8'h04, d, r);
    chk(d[0], 1'b1);
    ins(8'hac, 8'h80, 8'h00, 8'h00);
    for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
    for (int i = 0; i < 3; i++) byte_rw();
    p = 5'($random(seed));
    prog_u.xfer(8'h50, rx);
    prog_u.xfer({3'b000, p}, rx);
    for (int i = 0; i < 256; i++) begin
      v = 8'($random(seed));
      mem[{p, i[7:0]}] = v;
      prog_u.xfer(v, rx);
    end
    sent += 516;
    idle();
    prog_u.xfer(8'h30, rx);
    prog_u.xfer({3'b000, p}, rx);
    for (int i = 0; i < 256; i++) begin
      prog_u.xfer(8'h00, rx);
      chk(rx, mem[{p, i[7:0]}]);
    end
    ins(8'h20, {3'b000, p}, 8'hff, 8'h00);
    chk(rx, mem[{p, 8'hff}]);
    for (int m = 1; m < 4; m++) begin
      ins(8'hac, {6'b111000, 2'(m)}, 8'h00, 8'h00);
      lk[m-1] = 1'b1;
      ins(8'h24, 8'h00, 8'h00, 8'h00);
      chk(rx, {3'b000, lk, 2'b00});
      rd(8'h04, d, r);
      chk(d[5:3], lk);
    end
    byte_rw();
    wr(8'h04, 32'hffff_ffff, 2'h0);
    wr(8'h0c, 32'h0, 2'h2);
    rd(8'h0c, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    wr(8'h00, 32'h0, 2'h0);
    ins(8'h24, 8'h00, 8'h00, 8'h00);
    sent -= 4;
    wr(8'h00, 32'h1, 2'h0);
    rd(8'h08, d, r);
    chk(d[15:0], sent[15:0]);
    final_report();
  end
endmodule
